// ==== core/irq_ctrl.sv ====
`timescale 1ns/100ps
// What this block does
// - per-pin two-bit edge select: off, rising, falling, both edges
// - ext pin flag sets on each transition of the selected type
// - ext request vectored with master, pin enable, edge chosen, stack free
// - ext service clears its flag and the master enable
// - shared pin interrupts only with enable set and direction input
// - one option turns noise filter on for both ext pins and the peripheral pin
// - peripheral pin flag sets on each falling edge when pin selected
// - peripheral service clears master and shared flag, keeps pin flag
// - timer overflow sets flag; vectors to 0CH or 10H when enabled
// - timer service clears its flag and the master enable
// - serial byte done sets flag; vectors to 14H when enabled
// - serial service clears its flag and the master enable
// - shared flag sets when any merged source fires with its own enable set
// - shared flag vectored to 18H with master, shared enable, stack free
// - shared service clears shared flag and master; sources stay set
// - conversion flag reaches shared vector only with all enables set
// - first source register: flags bits 7..4, enables 3..0, reset zero
// - second source register: flags 6..4, enables 2..0, bits 7,3 zero
// - fixed priority ext0, ext1, timer0, timer1, serial, shared
// - master enable is bit 0; cleared means nothing is vectored
// - no acknowledge while stack full; flag waits for stack space
// - wake-up pulse on any flag rising, whatever the enables
module irq_ctrl
  import irq_ctrl_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       ext_pin_zero,
  input  wire logic       ext_pin_one,
  input  wire logic       periph_irq_pin,
  input  wire logic       ext_zero_is_input,
  input  wire logic       ext_one_is_input,
  input  wire logic       periph_pin_mode,
  input  wire logic       filter_option,
  input  wire logic       timer_zero_ovf,
  input  wire logic       timer_one_ovf,
  input  wire logic       serial_byte_done,
  input  wire logic       conversion_done,
  input  wire logic       timebase_zero_ovf,
  input  wire logic       timebase_one_ovf,
  input  wire logic       comparator_event,
  input  wire logic       nvm_cycle_done,
  input  wire logic       low_voltage_event,
  input  wire logic       stack_full,
  input  wire logic       irq_ack,
  output logic            irq_req,
  output logic      [7:0] irq_vector,
  output logic            wake_up,
  output logic            pin_filter_on
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0]               s1;
    logic [2:0]               s2;
    logic [2:0][FILT_LEN-1:0] hist;
    logic [2:0]               lvl;
    logic [7:0]               main_a;
    logic [7:0]               main_b;
    logic [7:0]               msrc_a;
    logic [7:0]               msrc_b;
    logic [3:0]               edge_sel;
    logic [7:0]               rdata;
    logic                     req;
    logic [7:0]               vec;
    logic                     wake;
    logic                     filt;
  } state_s;

  state_s st_ff;
  state_s nxt_st;
  logic [2:0] lvl_n;
  logic [2:0] rise;
  logic [2:0] fall;
  logic [1:0] ev_ext;
  logic       ev_pef;
  logic       ev_mff;
  logic [5:0] pend;

  function automatic logic [12:0] all_flags(input state_s s);
    all_flags = {s.main_a[6:4], s.main_b[6:4], s.msrc_a[7:4],
                 s.msrc_b[6:4]};
  endfunction

  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic r, input logic f);
    edge_hit = (sel == EDGE_RISE && r) || (sel == EDGE_FALL && f) ||
               (sel == EDGE_BOTH && (r || f));
  endfunction

  always_comb begin
    nxt_st = st_ff;
    // -------------------------------------------------------------
    // pin synchroniser and noise filter
    // -------------------------------------------------------------
    nxt_st.s1   = {periph_irq_pin, ext_pin_one, ext_pin_zero};
    nxt_st.s2   = st_ff.s1;
    nxt_st.filt = filter_option;
    lvl_n       = st_ff.s2;
    for (int i = 0; i < 3; i++) begin
      nxt_st.hist[i] = {st_ff.hist[i][FILT_LEN-2:0], st_ff.s2[i]};
      // filtered level moves only after a full stable run
      if (st_ff.filt) begin
        if (&st_ff.hist[i])
          lvl_n[i] = 1'b1;
        else if (~|st_ff.hist[i])
          lvl_n[i] = 1'b0;
        else
          lvl_n[i] = st_ff.lvl[i];
      end
    end
    nxt_st.lvl = lvl_n;
    rise = lvl_n & ~st_ff.lvl;
    fall = ~lvl_n & st_ff.lvl;
    ev_ext[0] = edge_hit(st_ff.edge_sel[1:0], rise[0], fall[0]) &&
                st_ff.main_a[B_EXT_ZERO_ENABLE] && ext_zero_is_input;
    ev_ext[1] = edge_hit(st_ff.edge_sel[3:2], rise[1], fall[1]) &&
                st_ff.main_a[B_EXT_ONE_ENABLE] && ext_one_is_input;
    ev_pef = fall[2] && periph_pin_mode;
    ev_mff =
      (ev_pef            && st_ff.msrc_a[B_PERIPH_PIN_ENABLE]) ||
      (timebase_one_ovf  && st_ff.msrc_a[B_TIMEBASE_ONE_EN])   ||
      (timebase_zero_ovf && st_ff.msrc_a[B_TIMEBASE_ZERO_EN])  ||
      (conversion_done   && st_ff.msrc_a[B_CONVERSION_EN])     ||
      (low_voltage_event && st_ff.msrc_b[B_LOW_VOLTAGE_EN])    ||
      (nvm_cycle_done    && st_ff.msrc_b[B_NVM_CYCLE_EN])      ||
      (comparator_event  && st_ff.msrc_b[B_COMPARATOR_EN]);

    // -------------------------------------------------------------
    // register writes and reads
    // -------------------------------------------------------------
    nxt_st.rdata = RST_BYTE;
    if (wr) begin
      case (addr)
        OFS_MAIN_A: nxt_st.main_a   = wdata & MASK_MAIN_A;
        OFS_MAIN_B: nxt_st.main_b   = wdata & MASK_MAIN_B;
        OFS_MSRC_A: nxt_st.msrc_a   = wdata & MASK_MSRC_A;
        OFS_MSRC_B: nxt_st.msrc_b   = wdata & MASK_MSRC_B;
        OFS_EDGE:   nxt_st.edge_sel = wdata[3:0] & MASK_EDGE;
        default: ;
      endcase
    end
    if (rd) begin
      case (addr)
        OFS_MAIN_A: nxt_st.rdata = st_ff.main_a;
        OFS_MAIN_B: nxt_st.rdata = st_ff.main_b;
        OFS_MSRC_A: nxt_st.rdata = st_ff.msrc_a;
        OFS_MSRC_B: nxt_st.rdata = st_ff.msrc_b;
        OFS_EDGE:   nxt_st.rdata = {4'h0, st_ff.edge_sel};
        default:    nxt_st.rdata = RST_BYTE;
      endcase
    end

    // -------------------------------------------------------------
    // service: clear the granted flag and the master enable
    // -------------------------------------------------------------
    if (irq_ack && st_ff.req) begin
      nxt_st.main_a[B_MASTER_IRQ_ENABLE] = 1'b0;
      case (st_ff.vec)
        VEC_EXT_ZERO: nxt_st.main_a[B_EXT_ZERO_FLAG]    = 1'b0;
        VEC_EXT_ONE:  nxt_st.main_a[B_EXT_ONE_FLAG]     = 1'b0;
        VEC_TIMER0:   nxt_st.main_a[B_TIMER_ZERO_FLAG]  = 1'b0;
        VEC_TIMER1:   nxt_st.main_b[B_TIMER_ONE_FLAG]   = 1'b0;
        VEC_SERIAL:   nxt_st.main_b[B_SERIAL_BYTE_FLAG] = 1'b0;
        // source flags stay for software to clear
        VEC_SHARED:   nxt_st.main_b[B_SHARED_VECTOR_FLAG] = 1'b0;
        default: ;
      endcase
    end

    // -------------------------------------------------------------
    // hardware sets, winning over any clear in the same cycle
    // -------------------------------------------------------------
    if (ev_ext[0]) nxt_st.main_a[B_EXT_ZERO_FLAG] = 1'b1;
    if (ev_ext[1]) nxt_st.main_a[B_EXT_ONE_FLAG]  = 1'b1;
    if (timer_zero_ovf) nxt_st.main_a[B_TIMER_ZERO_FLAG] = 1'b1;
    if (timer_one_ovf)  nxt_st.main_b[B_TIMER_ONE_FLAG]  = 1'b1;
    if (serial_byte_done)
      nxt_st.main_b[B_SERIAL_BYTE_FLAG] = 1'b1;
    if (ev_mff) nxt_st.main_b[B_SHARED_VECTOR_FLAG] = 1'b1;
    if (ev_pef)
      nxt_st.msrc_a[B_PERIPH_PIN_ENABLE + SRC_FLAG_DIST] = 1'b1;
    if (timebase_one_ovf)
      nxt_st.msrc_a[B_TIMEBASE_ONE_EN + SRC_FLAG_DIST] = 1'b1;
    if (timebase_zero_ovf)
      nxt_st.msrc_a[B_TIMEBASE_ZERO_EN + SRC_FLAG_DIST] = 1'b1;
    if (conversion_done)
      nxt_st.msrc_a[B_CONVERSION_EN + SRC_FLAG_DIST] = 1'b1;
    if (low_voltage_event)
      nxt_st.msrc_b[B_LOW_VOLTAGE_EN + SRC_FLAG_DIST] = 1'b1;
    if (nvm_cycle_done)
      nxt_st.msrc_b[B_NVM_CYCLE_EN + SRC_FLAG_DIST] = 1'b1;
    if (comparator_event)
      nxt_st.msrc_b[B_COMPARATOR_EN + SRC_FLAG_DIST] = 1'b1;

    // -------------------------------------------------------------
    // request qualification and fixed priority
    // -------------------------------------------------------------
    pend[0] = nxt_st.main_a[B_EXT_ZERO_FLAG] &&
              nxt_st.main_a[B_EXT_ZERO_ENABLE] &&
              nxt_st.edge_sel[1:0] != EDGE_OFF;
    pend[1] = nxt_st.main_a[B_EXT_ONE_FLAG] &&
              nxt_st.main_a[B_EXT_ONE_ENABLE] &&
              nxt_st.edge_sel[3:2] != EDGE_OFF;
    pend[2] = nxt_st.main_a[B_TIMER_ZERO_FLAG] &&
              nxt_st.main_a[B_TIMER_ZERO_ENABLE];
    pend[3] = nxt_st.main_b[B_TIMER_ONE_FLAG] &&
              nxt_st.main_b[B_TIMER_ONE_ENABLE];
    pend[4] = nxt_st.main_b[B_SERIAL_BYTE_FLAG] &&
              nxt_st.main_b[B_SERIAL_IRQ_ENABLE];
    pend[5] = nxt_st.main_b[B_SHARED_VECTOR_FLAG] &&
              nxt_st.main_b[B_SHARED_VECTOR_EN];
    nxt_st.req = nxt_st.main_a[B_MASTER_IRQ_ENABLE] && !stack_full &&
                 (|pend);
    if (pend[0])      nxt_st.vec = VEC_EXT_ZERO;
    else if (pend[1]) nxt_st.vec = VEC_EXT_ONE;
    else if (pend[2]) nxt_st.vec = VEC_TIMER0;
    else if (pend[3]) nxt_st.vec = VEC_TIMER1;
    else if (pend[4]) nxt_st.vec = VEC_SERIAL;
    else if (pend[5]) nxt_st.vec = VEC_SHARED;
    else              nxt_st.vec = VEC_NONE;
    if (!nxt_st.req)
      nxt_st.vec = VEC_NONE;

    nxt_st.wake = |(all_flags(nxt_st) & ~all_flags(st_ff));
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata         = st_ff.rdata;
  assign irq_req       = st_ff.req;
  assign irq_vector    = st_ff.vec;
  assign wake_up       = st_ff.wake;
  assign pin_filter_on = st_ff.filt;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_grant(logic [7:0] v);
    irq_ack && st_ff.req && st_ff.vec == v;
  endsequence

  property p_edge_off;
    @(posedge clk) disable iff (!rstn)
    st_ff.edge_sel[1:0] == EDGE_OFF && !wr &&
    !st_ff.main_a[B_EXT_ZERO_FLAG] |=> !st_ff.main_a[B_EXT_ZERO_FLAG];
  endproperty
  a_edge_off: assert property (p_edge_off)
    else $error("ext0 flag set with edge select off");

  property p_rise_sets;
    @(posedge clk) disable iff (!rstn)
    st_ff.edge_sel[1:0] == EDGE_RISE && rise[0] &&
    st_ff.main_a[B_EXT_ZERO_ENABLE] && ext_zero_is_input
    |=> st_ff.main_a[B_EXT_ZERO_FLAG];
  endproperty
  a_rise_sets: assert property (p_rise_sets)
    else $error("rising edge did not set ext0 flag");

  property p_ext_service;
    @(posedge clk) disable iff (!rstn)
    s_grant(VEC_EXT_ZERO) ##0 !ev_ext[0] && !wr |=>
    !st_ff.main_a[B_EXT_ZERO_FLAG] && !st_ff.main_a[B_MASTER_IRQ_ENABLE];
  endproperty
  a_ext_service: assert property (p_ext_service)
    else $error("ext0 service left flag or master set");

  property p_shared_keeps_src;
    @(posedge clk) disable iff (!rstn)
    s_grant(VEC_SHARED) ##0 !wr |=>
    ($past(st_ff.msrc_a[7:4]) & ~st_ff.msrc_a[7:4]) == 4'h0 &&
    ($past(st_ff.msrc_b[6:4]) & ~st_ff.msrc_b[6:4]) == 3'h0 &&
    !st_ff.main_a[B_MASTER_IRQ_ENABLE];
  endproperty
  a_shared_keeps_src: assert property (p_shared_keeps_src)
    else $error("shared service touched source flags");

  property p_req_needs_master;
    @(posedge clk) disable iff (!rstn)
    irq_req |-> st_ff.main_a[B_MASTER_IRQ_ENABLE] && !$past(stack_full);
  endproperty
  a_req_needs_master: assert property (p_req_needs_master)
    else $error("request without master enable or with stack full");

  property p_priority;
    @(posedge clk) disable iff (!rstn)
    irq_req && st_ff.main_a[B_EXT_ZERO_FLAG] &&
    st_ff.main_a[B_EXT_ZERO_ENABLE] && st_ff.edge_sel[1:0] != EDGE_OFF
    |-> irq_vector == VEC_EXT_ZERO;
  endproperty
  a_priority: assert property (p_priority)
    else $error("ext0 not given top priority");

  property p_timer_vec;
    @(posedge clk) disable iff (!rstn)
    irq_req && irq_vector == VEC_TIMER0 |->
    st_ff.main_a[B_TIMER_ZERO_FLAG] && st_ff.main_a[B_TIMER_ZERO_ENABLE];
  endproperty
  a_timer_vec: assert property (p_timer_vec)
    else $error("timer0 vector without pending timer0");

  property p_wake;
    @(posedge clk) disable iff (!rstn)
    |(all_flags(st_ff) & ~$past(all_flags(st_ff))) |-> wake_up;
  endproperty
  a_wake: assert property (p_wake)
    else $error("flag rose without wake-up");

  property p_msb_read;
    @(posedge clk) disable iff (!rstn)
    rd && addr == OFS_MSRC_B |=> rdata[7] == 1'b0 && rdata[3] == 1'b0 &&
    rdata[6:4] == $past(st_ff.msrc_b[6:4]);
  endproperty
  a_msb_read: assert property (p_msb_read)
    else $error("second source register read wrong");

  property p_timer_service;
    @(posedge clk) disable iff (!rstn)
    s_grant(VEC_TIMER0) ##0 !timer_zero_ovf && !wr |=>
    !st_ff.main_a[B_TIMER_ZERO_FLAG] && !st_ff.main_a[B_MASTER_IRQ_ENABLE];
  endproperty
  a_timer_service: assert property (p_timer_service)
    else $error("timer0 service left flag or master set");

  property p_serial_service;
    @(posedge clk) disable iff (!rstn)
    s_grant(VEC_SERIAL) ##0 !serial_byte_done && !wr |=>
    !st_ff.main_b[B_SERIAL_BYTE_FLAG] && !st_ff.main_a[B_MASTER_IRQ_ENABLE];
  endproperty
  a_serial_service: assert property (p_serial_service)
    else $error("serial service left flag or master set");

  property p_shared_clears;
    @(posedge clk) disable iff (!rstn)
    s_grant(VEC_SHARED) ##0 !ev_mff && !wr |=>
    !st_ff.main_b[B_SHARED_VECTOR_FLAG];
  endproperty
  a_shared_clears: assert property (p_shared_clears)
    else $error("shared service left shared flag set");

  property p_stack_block;
    @(posedge clk) disable iff (!rstn)
    stack_full |=> !irq_req && irq_vector == VEC_NONE;
  endproperty
  a_stack_block: assert property (p_stack_block)
    else $error("request raised while stack full");

  property p_periph_fall;
    @(posedge clk) disable iff (!rstn)
    fall[2] && periph_pin_mode |=>
    st_ff.msrc_a[B_PERIPH_PIN_ENABLE + SRC_FLAG_DIST];
  endproperty
  a_periph_fall: assert property (p_periph_fall)
    else $error("peripheral pin fall did not set its flag");

  property p_shared_sets;
    @(posedge clk) disable iff (!rstn)
    conversion_done && st_ff.msrc_a[B_CONVERSION_EN] |=>
    st_ff.main_b[B_SHARED_VECTOR_FLAG];
  endproperty
  a_shared_sets: assert property (p_shared_sets)
    else $error("enabled source did not set shared flag");

  property p_ext_one_vec;
    @(posedge clk) disable iff (!rstn)
    irq_req && irq_vector == VEC_EXT_ONE |->
    st_ff.main_a[B_EXT_ONE_FLAG] && st_ff.main_a[B_EXT_ONE_ENABLE] &&
    st_ff.edge_sel[3:2] != EDGE_OFF;
  endproperty
  a_ext_one_vec: assert property (p_ext_one_vec)
    else $error("ext1 vector without qualified ext1 request");

endmodule

// ==== pkg/irq_ctrl_pkg.sv ====
package irq_ctrl_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [2:0] OFS_MAIN_A  = 3'h0;
  localparam logic [2:0] OFS_MAIN_B  = 3'h1;
  localparam logic [2:0] OFS_MSRC_A  = 3'h2;
  localparam logic [2:0] OFS_MSRC_B  = 3'h3;
  localparam logic [2:0] OFS_EDGE    = 3'h4;

  // ---------------------------------------------------------------
  // writable bit masks and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] MASK_MAIN_A = 8'h7F;
  localparam logic [7:0] MASK_MAIN_B = 8'h77;
  localparam logic [7:0] MASK_MSRC_A = 8'hFF;
  localparam logic [7:0] MASK_MSRC_B = 8'h77;
  localparam logic [3:0] MASK_EDGE   = 4'hF;
  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [3:0] RST_EDGE    = 4'h0;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int B_TIMER_ZERO_FLAG    = 6;
  localparam int B_EXT_ONE_FLAG       = 5;
  localparam int B_EXT_ZERO_FLAG      = 4;
  localparam int B_TIMER_ZERO_ENABLE  = 3;
  localparam int B_EXT_ONE_ENABLE     = 2;
  localparam int B_EXT_ZERO_ENABLE    = 1;
  localparam int B_MASTER_IRQ_ENABLE  = 0;
  localparam int B_SHARED_VECTOR_FLAG = 6;
  localparam int B_SERIAL_BYTE_FLAG   = 5;
  localparam int B_TIMER_ONE_FLAG     = 4;
  localparam int B_SHARED_VECTOR_EN   = 2;
  localparam int B_SERIAL_IRQ_ENABLE  = 1;
  localparam int B_TIMER_ONE_ENABLE   = 0;
  // shared-vector sources: flag bit = enable bit + this distance
  localparam int SRC_FLAG_DIST        = 4;
  localparam int B_PERIPH_PIN_ENABLE  = 3;
  localparam int B_TIMEBASE_ONE_EN    = 2;
  localparam int B_TIMEBASE_ZERO_EN   = 1;
  localparam int B_CONVERSION_EN      = 0;
  localparam int B_LOW_VOLTAGE_EN     = 2;
  localparam int B_NVM_CYCLE_EN       = 1;
  localparam int B_COMPARATOR_EN      = 0;

  // ---------------------------------------------------------------
  // edge select codes, vectors, filter length
  // ---------------------------------------------------------------
  localparam logic [1:0] EDGE_OFF     = 2'h0;
  localparam logic [1:0] EDGE_RISE    = 2'h1;
  localparam logic [1:0] EDGE_FALL    = 2'h2;
  localparam logic [1:0] EDGE_BOTH    = 2'h3;
  localparam logic [7:0] VEC_NONE     = 8'h00;
  localparam logic [7:0] VEC_EXT_ZERO = 8'h04;
  localparam logic [7:0] VEC_EXT_ONE  = 8'h08;
  localparam logic [7:0] VEC_TIMER0   = 8'h0C;
  localparam logic [7:0] VEC_TIMER1   = 8'h10;
  localparam logic [7:0] VEC_SERIAL   = 8'h14;
  localparam logic [7:0] VEC_SHARED   = 8'h18;
  localparam int         FILT_LEN     = 3;

endpackage

// ==== verification/core_model.sv ====
`timescale 1ns/100ps
// ---------------------------------------------
// core side: acknowledges a standing request
// ---------------------------------------------
module core_model (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       irq_req,
  input  wire logic [7:0] irq_vector,
  input  wire logic [1:0] ack_dly,
  output logic            irq_ack,
  output logic      [7:0] taken_vec,
  output logic      [7:0] taken_cnt
);
  logic [1:0] wait_cnt;

  // ack is a one-cycle pulse, only while a request stands
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_ack   <= 1'b0;
      wait_cnt  <= 2'h0;
      taken_vec <= 8'h00;
      taken_cnt <= 8'h00;
    end else if (irq_ack) begin
      irq_ack  <= 1'b0;
      wait_cnt <= 2'h0;
      if (irq_req) begin
        taken_vec <= irq_vector;
        taken_cnt <= taken_cnt + 8'h01;
      end
    end else if (irq_req) begin
      if (wait_cnt == ack_dly) irq_ack <= 1'b1;
      else wait_cnt <= wait_cnt + 2'h1;
    end else begin
      wait_cnt <= 2'h0;
    end
  end
endmodule

// ==== verification/tb_top.sv ====
`timescale 1ns/100ps
module tb_top import irq_ctrl_pkg::*;;
  logic       clk = 0, rstn = 0, wr = 0, rd = 0, stf = 0, filt = 0;
  logic [2:0] addr = 0, pins = 0;
  logic [2:0] ra;
  logic       pmode = 1;
  logic [7:0] wdata = 0, rdata, vec, v, d, n, tv, tc;
  logic [8:0] ev = 0;
  logic [1:0] dly = 0, dir = 2'b11;
  logic       irq_req, irq_ack, wake_up, pf;
  int         fail_count = 0, checked = 0, wakes = 0, w;
  // cols: main_a, main_b, msrc_a, event, vector, then reg values after ack
  localparam logic [7:0] T [4][8] = '{
    '{8'h09, 8'h00, 8'h00, 8'h00, 8'h0C, 8'h08, 8'h00, 8'h00},
    '{8'h01, 8'h01, 8'h00, 8'h01, 8'h10, 8'h00, 8'h01, 8'h00},
    '{8'h01, 8'h02, 8'h00, 8'h02, 8'h14, 8'h00, 8'h02, 8'h00},
    '{8'h01, 8'h04, 8'h01, 8'h03, 8'h18, 8'h00, 8'h04, 8'h11}};

  always #20 clk = ~clk;
  always @(posedge clk) if (wake_up === 1'b1) wakes++;

  irq_ctrl dut_u (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .ext_pin_zero(pins[0]),
    .ext_pin_one(pins[1]), .periph_irq_pin(pins[2]),
    .ext_zero_is_input(dir[0]), .ext_one_is_input(dir[1]),
    .periph_pin_mode(pmode), .filter_option(filt),
    .timer_zero_ovf(ev[0]), .timer_one_ovf(ev[1]),
    .serial_byte_done(ev[2]), .conversion_done(ev[3]),
    .timebase_zero_ovf(ev[4]), .timebase_one_ovf(ev[5]),
    .comparator_event(ev[6]), .nvm_cycle_done(ev[7]),
    .low_voltage_event(ev[8]), .stack_full(stf), .irq_ack(irq_ack),
    .irq_req(irq_req), .irq_vector(vec), .wake_up(wake_up),
    .pin_filter_on(pf));

  core_model core_u (
    .clk(clk), .rstn(rstn), .irq_req(irq_req), .irq_vector(vec),
    .ack_dly(dly), .irq_ack(irq_ack), .taken_vec(tv), .taken_cnt(tc));

  // ---------------------------------------------
  // bus, event and compare helpers
  // ---------------------------------------------
  task automatic wr_r(input logic [2:0] a, input logic [7:0] x);
    @(posedge clk);
    addr <= a; wdata <= x; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_r(input logic [2:0] a, output logic [7:0] x);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 x = rdata;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic pulse(input logic [7:0] i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev <= '0;
  endtask
  task automatic wait_ack(input logic [7:0] n0);
    int k;
    for (k = 0; k < 40 && tc === n0; k++) @(posedge clk);
    chk(8'(tc - n0), 8'h01);
  endtask
  function automatic logic [7:0] mask_of(input logic [2:0] a);
    case (a)
      OFS_MAIN_A: return MASK_MAIN_A;
      OFS_MAIN_B: return MASK_MAIN_B;
      OFS_MSRC_A: return MASK_MSRC_A;
      OFS_MSRC_B: return MASK_MSRC_B;
      OFS_EDGE:   return {4'h0, MASK_EDGE};
      default:    return 8'h00;
    endcase
  endfunction
  task automatic conclude;
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #200000;
    fail_count++;
    conclude();
  end

  // ---------------------------------------------
  // tests
  // ---------------------------------------------
  initial begin
    v = $urandom(32'h478452e1);
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd_r(3'(i), v); chk(v, RST_BYTE);
    end
    $display("test reset values done");
    for (int i = 0; i < 24; i++) begin
      ra = 3'($urandom % 8);
      d = 8'($urandom);
      if (ra == OFS_MAIN_A) d[0] = 1'b0;
      wr_r(ra, d);
      rd_r(ra, v);
      chk(v, d & mask_of(ra));
    end
    for (int i = 0; i < 5; i++) wr_r(3'(i), 8'h00);
    $display("test register access done");
    w = wakes;
    pulse(8'h06);
    rd_r(OFS_MSRC_B, v); chk(v, 8'h10);
    rd_r(OFS_MAIN_B, v); chk(v, 8'h00);
    chk(8'(wakes - w), 8'h01);
    wr_r(OFS_MSRC_B, 8'h00);
    $display("test wake-up done");
    for (int i = 0; i < 4; i++) begin
      dly <= 2'($urandom % 4);
      wr_r(OFS_MSRC_A, T[i][2]);
      wr_r(OFS_MAIN_B, T[i][1]);
      wr_r(OFS_MAIN_A, T[i][0]);
      n = tc;
      pulse(T[i][3]);
      wait_ack(n);
      chk(tv, T[i][4]);
      rd_r(OFS_MAIN_A, v); chk(v, T[i][5]);
      rd_r(OFS_MAIN_B, v); chk(v, T[i][6]);
      rd_r(OFS_MSRC_A, v); chk(v, T[i][7]);
      for (int j = 0; j < 3; j++) wr_r(3'(j), 8'h00);
    end
    $display("test vectors done");
    stf <= 1'b1;
    wr_r(OFS_MAIN_A, 8'h09);
    pulse(8'h00);
    repeat (6) @(posedge clk);
    chk({7'h0, irq_req}, 8'h00);
    rd_r(OFS_MAIN_A, v); chk(v, 8'h49);
    n = tc;
    stf <= 1'b0;
    wait_ack(n);
    chk(tv, VEC_TIMER0);
    $display("test stack full done");
    wr_r(OFS_EDGE, 8'h0F);
    n = tc;
    wr_r(OFS_MAIN_A, 8'h7F);
    wait_ack(n);
    chk(tv, VEC_EXT_ZERO);
    rd_r(OFS_MAIN_A, v); chk(v, 8'h6E);
    n = tc;
    wr_r(OFS_MAIN_A, 8'h6F);
    wait_ack(n);
    chk(tv, VEC_EXT_ONE);
    rd_r(OFS_MAIN_A, v); chk(v, 8'h4E);
    wr_r(OFS_MAIN_A, 8'h06);
    $display("test priority done");
    for (int c = 0; c < 4; c++) begin
      wr_r(OFS_EDGE, {4'h0, 2'(c), 2'(c)});
      pins <= 3'h7;
      repeat (8) @(posedge clk);
      rd_r(OFS_MAIN_A, v); chk(v, c[0] ? 8'h36 : 8'h06);
      rd_r(OFS_MSRC_A, v); chk(v, 8'h00);
      wr_r(OFS_MAIN_A, 8'h06);
      pins <= 3'h0;
      repeat (8) @(posedge clk);
      rd_r(OFS_MAIN_A, v); chk(v, c[1] ? 8'h36 : 8'h06);
      rd_r(OFS_MSRC_A, v); chk(v, 8'h80);
      wr_r(OFS_MSRC_A, 8'h00);
      wr_r(OFS_MAIN_A, 8'h06);
    end
    dir <= 2'b10;
    pins <= 3'h7;
    repeat (8) @(posedge clk);
    rd_r(OFS_MAIN_A, v); chk(v, 8'h26);
    pmode <= 1'b0;
    pins <= 3'h3;
    repeat (8) @(posedge clk);
    rd_r(OFS_MSRC_A, v);
    chk(v, 8'h00);
    pmode <= 1'b1;
    wr_r(OFS_MAIN_A, 8'h06);
    filt <= 1'b1;
    repeat (3) @(posedge clk);
    chk({7'h0, pf}, 8'h01);
    // one-cycle glitch on ext1 must be swallowed by the filter
    pins <= 3'h1;
    @(posedge clk);
    pins <= 3'h3;
    repeat (8) @(posedge clk);
    rd_r(OFS_MAIN_A, v);
    chk(v, 8'h06);
    pins <= 3'h1;
    repeat (10) @(posedge clk);
    rd_r(OFS_MAIN_A, v);
    chk(v, 8'h26);
    $display("test pins done");
    conclude();
  end
endmodule
